// ==== rtl/satsc_top.sv ====
// Lookup table status and aging configuration registers on a Wishbone slave
//
// Our own choice: the Wishbone register port.
`timescale 1ns/100ps
`include "satsc_map.svh"
module satsc_top
    import satsc_pkg::*;
#(
    parameter int INIT_CYCLES = `SATSC_INIT_CYCLES,
    parameter int MS_CYCLES   = `SATSC_MS_CYCLES
) (
    input  wire logic        i_mclk,          // 25 MHz fabric clock
    input  wire logic        i_sys_rst,       // Sync reset, active high
    input  wire logic        i_wb_cyc,        // Wishbone cycle
    input  wire logic        i_wb_stb,        // Wishbone strobe
    input  wire logic        i_wb_we,         // Wishbone write
    input  wire logic [3:0]  i_wb_sel,        // Byte lanes
    input  wire logic [15:0] i_wb_adr,        // Byte address
    input  wire logic [31:0] i_wb_dat,        // Write data
    output logic [31:0]      o_wb_dat,        // Read data
    output logic             o_wb_ack,        // Acknowledge
    input  wire logic        i_cmd_start,     // Table command issued, pulse
    input  wire logic        i_cmd_done,      // Table command finished, pulse
    input  wire logic        i_entry_load,    // Capture entry, pulse
    input  wire satsc_entry_type i_entry,     // Entry from the table engine
    input  wire logic        i_global_da_prio,// Global DA highest priority
    input  wire logic [47:0] i_lookup_da,     // Destination being stored or looked up
    output logic             o_prio_use,      // Entry priority applies
    output logic [2:0]       o_prio,          // Entry priority value
    output logic [2:0]       o_dest_mask,     // Destination port mask
    output logic             o_bcast_ok,      // Destination may use the table
    output logic             o_rx_discard,    // Drop received packets
    output logic             o_init_busy,     // Table clear running
    output logic             o_age_sweep,     // Age non-static entries, pulse
    output logic             o_age_en,        // Aging enabled
    output logic             o_age_test       // Millisecond aging units
);
    typedef struct packed {
        satsc_phase_type phase;
        logic [31:0]     init_cnt;
        logic            init_done;
        logic            pending;
        satsc_cfg_type   cfg;
        satsc_entry_type entry;
        logic [31:0]     rdat;
        logic            ack;
        logic            prio_use;
        logic [2:0]      prio;
        logic [2:0]      dest_mask;
        logic            bcast_ok;
        logic            discard;
        logic            sweep;
    } satsc_st_type;

    satsc_st_type st_r, st_nxt;
    logic         sweep_w;
    logic         req_w;
    logic [15:0]  idx_w;

    satsc_age_tick #(
        .MS_CYCLES (MS_CYCLES)
    ) satsc_age_tick_inst (
        .i_mclk     (i_mclk),
        .i_sys_rst  (i_sys_rst),
        .i_run      (st_r.cfg.age_en && st_r.init_done),
        .i_test     (st_r.cfg.age_test),
        .i_age_time (st_r.cfg.age_time),
        .o_sweep    (sweep_w)
    );

    // Word index from the byte address; low bits ignored
    assign idx_w = {2'b00, i_wb_adr[15:2]};
    assign req_w = i_wb_cyc && i_wb_stb && !st_r.ack;

    function automatic logic [2:0] port_mask(input logic [2:0] code);
        logic [2:0] m;
        m = 3'h0;
        if (!code[2]) begin
            case (code[1:0])
                2'b00:   m = 3'h1;
                2'b01:   m = 3'h2;
                2'b10:   m = 3'h4;
                default: m = 3'h0;
            endcase
        end else begin
            case (code[1:0])
                2'b00:   m = 3'h3;
                2'b01:   m = 3'h5;
                2'b10:   m = 3'h6;
                default: m = 3'h7;
            endcase
        end
        return m;
    endfunction : port_mask

    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        st_nxt.sweep = sweep_w && st_r.cfg.age_en;
        case (st_r.phase)
            SATSC_INIT: begin
                if (st_r.init_cnt >= 32'(INIT_CYCLES - 1)) begin
                    st_nxt.phase = SATSC_IDLE;
                    st_nxt.init_done = 1'b1;
                end else begin
                    st_nxt.init_cnt = st_r.init_cnt + 32'h0000_0001;
                end
            end
            SATSC_IDLE: begin
                if (i_cmd_start) begin
                    st_nxt.phase = SATSC_BUSY;
                    st_nxt.pending = 1'b1;
                end
            end
            SATSC_BUSY: begin
                if (i_cmd_done) begin
                    st_nxt.phase = SATSC_IDLE;
                    st_nxt.pending = 1'b0;
                end
            end
            default: st_nxt.phase = SATSC_INIT;
        endcase
        st_nxt.discard = (st_nxt.phase == SATSC_INIT);
        if (i_entry_load) begin
            st_nxt.entry = i_entry;
        end
        st_nxt.prio_use = st_r.entry.prio_en && i_global_da_prio;
        st_nxt.prio = st_r.entry.prio;
        st_nxt.dest_mask = port_mask(st_r.entry.ports);
        st_nxt.bcast_ok = !(&i_lookup_da) || st_r.cfg.allow_bcast;
        if (req_w) begin
            st_nxt.ack = 1'b1;
            st_nxt.rdat = 32'h0000_0000;
            if (idx_w == `SATSC_IDX_RDBK_HIGH) begin
                st_nxt.rdat = {4'h0, st_r.entry.end_tbl, st_r.entry.valid, st_r.entry.age1,
                               st_r.entry.stat, st_r.entry.age0, st_r.entry.prio_en,
                               st_r.entry.prio, st_r.entry.ports, st_r.entry.mac_tail};
            end else if (idx_w == `SATSC_IDX_CMD_STATUS) begin
                st_nxt.rdat = {30'h0000_0000, st_r.init_done, st_r.pending};
            end else if (idx_w == `SATSC_IDX_AGING_CFG) begin
                st_nxt.rdat = {4'h0, st_r.cfg.age_time, 13'h0000, st_r.cfg.allow_bcast,
                               st_r.cfg.age_en, st_r.cfg.age_test};
                if (i_wb_we) begin
                    if (i_wb_sel[0]) begin
                        st_nxt.cfg.allow_bcast = i_wb_dat[`SATSC_CFG_ALLOW_BCAST];
                        st_nxt.cfg.age_en = i_wb_dat[`SATSC_CFG_AGE_EN];
                        st_nxt.cfg.age_test = i_wb_dat[`SATSC_CFG_AGE_TEST];
                    end
                    if (i_wb_sel[2]) begin
                        st_nxt.cfg.age_time[7:0] = i_wb_dat[23:16];
                    end
                    if (i_wb_sel[3]) begin
                        st_nxt.cfg.age_time[11:8] = i_wb_dat[27:24];
                    end
                end
            end
            if (i_wb_we) begin
                st_nxt.rdat = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            st_r <= '0;
            st_r.phase <= SATSC_INIT;
            st_r.discard <= 1'b1;
            st_r.cfg.age_time <= `SATSC_AGE_TIME_RST;
            st_r.cfg.age_en <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_wb_dat = st_r.rdat;
    assign o_wb_ack = st_r.ack;
    assign o_prio_use = st_r.prio_use;
    assign o_prio = st_r.prio;
    assign o_dest_mask = st_r.dest_mask;
    assign o_bcast_ok = st_r.bcast_ok;
    assign o_rx_discard = st_r.discard;
    assign o_init_busy = st_r.discard;
    assign o_age_sweep = st_r.sweep;
    assign o_age_en = st_r.cfg.age_en;
    assign o_age_test = st_r.cfg.age_test;

    prio_gate_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (!st_r.entry.prio_en || !i_global_da_prio) |=> !o_prio_use
    ) else $error("priority ungated");

    prio_pass_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (st_r.entry.prio_en && i_global_da_prio) |=> o_prio_use
    ) else $error("priority dropped");

    prio_value_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        1'b1 |=> o_prio == $past(st_r.entry.prio)
    ) else $error("priority value wrong");

    port_single_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        !st_r.entry.ports[2] |=> $countones(o_dest_mask) <= 1
    ) else $error("single port wrong");

    port_all_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (st_r.entry.ports == 3'h7) |=> o_dest_mask == 3'h7
    ) else $error("all ports wrong");

    port_zero_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (st_r.entry.ports == 3'h0) |=> o_dest_mask == 3'h1
    ) else $error("port 0 code wrong");

    port_one_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (st_r.entry.ports == 3'h1) |=> o_dest_mask == 3'h2
    ) else $error("port 1 code wrong");

    port_two_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (st_r.entry.ports == 3'h2) |=> o_dest_mask == 3'h4
    ) else $error("port 2 code wrong");

    // Reserved code forwards nowhere rather than guessing a port
    port_resv_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (st_r.entry.ports == 3'h3) |=> o_dest_mask == 3'h0
    ) else $error("reserved code forwards");

    pair_low_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (st_r.entry.ports == 3'h4) |=> o_dest_mask == 3'h3
    ) else $error("pair 0 1 wrong");

    pair_mid_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (st_r.entry.ports == 3'h5) |=> o_dest_mask == 3'h5
    ) else $error("pair 0 2 wrong");

    pair_high_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (st_r.entry.ports == 3'h6) |=> o_dest_mask == 3'h6
    ) else $error("pair 1 2 wrong");

    mac_load_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_entry_load |=> st_r.entry.mac_tail == $past(i_entry.mac_tail)
    ) else $error("address tail not captured");

    init_len_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        $rose(st_r.init_done) |-> $past(st_r.init_cnt) == 32'(INIT_CYCLES - 1)
    ) else $error("init length wrong");

    init_drop_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        !st_r.init_done |-> o_rx_discard
    ) else $error("packet taken during init");

    init_end_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        st_r.init_done |-> !o_rx_discard
    ) else $error("packets dropped after init");

    done_sticky_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        st_r.init_done |=> st_r.init_done
    ) else $error("init done dropped");

    rst_clear_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        $past(i_sys_rst) |-> !st_r.init_done && !st_r.pending
    ) else $error("status not clear after reset");

    pend_set_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (st_r.phase == SATSC_IDLE && i_cmd_start) |=> st_r.pending
    ) else $error("pending late");

    pend_clear_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (st_r.phase == SATSC_BUSY && i_cmd_done) |=> !st_r.pending
    ) else $error("pending stuck");

    pend_hold_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (st_r.phase == SATSC_BUSY && !i_cmd_done) |=> st_r.pending
    ) else $error("pending lost early");

    cfg_rst_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        $past(i_sys_rst) |-> st_r.cfg.age_time == `SATSC_AGE_TIME_RST && o_age_en && !o_age_test
    ) else $error("aging config reset wrong");

    bcast_block_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (&i_lookup_da && !st_r.cfg.allow_bcast) |=> !o_bcast_ok
    ) else $error("broadcast allowed");

    bcast_pass_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (!(&i_lookup_da) || st_r.cfg.allow_bcast) |=> o_bcast_ok
    ) else $error("lookup wrongly blocked");

    ack_once_a: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        o_wb_ack |=> !o_wb_ack
    ) else $error("ack held");
endmodule : satsc_top

// ==== shared/satsc_map.svh ====
// Register offsets, field positions, reset values and timing counts for the lookup status block
`ifndef SATSC_MAP_SVH
`define SATSC_MAP_SVH

`define SATSC_IDX_RDBK_HIGH     16'h1806
`define SATSC_IDX_CMD_STATUS    16'h1808
`define SATSC_IDX_AGING_CFG     16'h1809
`define SATSC_ADDR_W            16
`define SATSC_CFG_AGE_TIME_LSB  16
`define SATSC_CFG_AGE_TIME_MSB  27
`define SATSC_CFG_ALLOW_BCAST   2
`define SATSC_CFG_AGE_EN        1
`define SATSC_CFG_AGE_TEST      0
`define SATSC_AGE_TIME_RST      12'h129
`define SATSC_CLK_HZ            25000000
`define SATSC_INIT_TIME_NS      20000
`define SATSC_INIT_CYCLES       ((`SATSC_INIT_TIME_NS * (`SATSC_CLK_HZ / 1000000)) / 1000)
`define SATSC_MS_CYCLES         (`SATSC_CLK_HZ / 1000)
`define SATSC_MS_PER_S          1000

`endif

// ==== shared/satsc_pkg.sv ====
// Types shared by the lookup status block
package satsc_pkg;

    typedef struct packed {
        logic [2:0]  prio;
        logic        prio_en;
        logic [2:0]  ports;
        logic [15:0] mac_tail;
        logic        valid;
        logic        end_tbl;
        logic        age1;
        logic        stat;
        logic        age0;
    } satsc_entry_type;

    typedef struct packed {
        logic [11:0] age_time;
        logic        allow_bcast;
        logic        age_en;
        logic        age_test;
    } satsc_cfg_type;

    typedef enum logic [1:0] {
        SATSC_INIT,
        SATSC_IDLE,
        SATSC_BUSY
    } satsc_phase_type;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [15:0] adr;
        logic [31:0] dat;
    } satsc_wb_req_type;

endpackage : satsc_pkg

// ==== rtl/satsc_age_tick.sv ====
// Aging time base: one-second or one-millisecond ticks and the aging sweep strobe
`timescale 1ns/100ps
`include "satsc_map.svh"
module satsc_age_tick
    import satsc_pkg::*;
#(
    parameter int MS_CYCLES = `SATSC_MS_CYCLES
) (
    input  wire logic        i_mclk,      // Fabric clock
    input  wire logic        i_sys_rst,   // Sync reset
    input  wire logic        i_run,       // Aging allowed
    input  wire logic        i_test,      // Millisecond units
    input  wire logic [11:0] i_age_time,  // Interval minus one
    output logic             o_sweep      // Aging interval elapsed
);
    typedef struct packed {
        logic [31:0] ms_cnt;
        logic [9:0]  sub_cnt;
        logic [11:0] unit_cnt;
        logic        sweep;
    } satsc_tick_st_type;

    satsc_tick_st_type st_r, st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.sweep = 1'b0;
        if (!i_run) begin
            st_nxt.ms_cnt = '0;
            st_nxt.sub_cnt = '0;
            st_nxt.unit_cnt = '0;
        end else if (st_r.ms_cnt == 32'(MS_CYCLES - 1)) begin
            st_nxt.ms_cnt = '0;
            // Test mode takes every millisecond as the unit
            if (i_test || st_r.sub_cnt == 10'(`SATSC_MS_PER_S - 1)) begin
                st_nxt.sub_cnt = '0;
                if (st_r.unit_cnt >= i_age_time) begin
                    st_nxt.unit_cnt = '0;
                    st_nxt.sweep = 1'b1;
                end else begin
                    st_nxt.unit_cnt = st_r.unit_cnt + 12'h001;
                end
            end else begin
                st_nxt.sub_cnt = st_r.sub_cnt + 10'h001;
            end
        end else begin
            st_nxt.ms_cnt = st_r.ms_cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_sweep = st_r.sweep;

    sweep_gated_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        !i_run |=> !o_sweep) else $error("sweep while aging off");
endmodule : satsc_age_tick

// ==== testbench/satsc_top_bench.sv ====
// Self-checking bench for the lookup status and aging configuration block
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module satsc_top_bench;
    import satsc_pkg::*;
    localparam int          INIT_N = 8;
    localparam int          MS_N   = 4;
    localparam logic [15:0] A_RDBK = 16'h6018;
    localparam logic [15:0] A_STS  = 16'h6020;
    localparam logic [15:0] A_CFG  = 16'h6024;
    logic            i_mclk = 1'b0;
    logic            rst = 1'b1;
    logic            cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0]      sel = 4'h0;
    logic [15:0]     adr = 16'h0000;
    logic [31:0]     wdat = 32'h0000_0000;
    logic [31:0]     rdat, rd;
    logic            ack, cmd_start = 1'b0, cmd_done = 1'b0, entry_load = 1'b0, gprio = 1'b0;
    satsc_entry_type entry = '0;
    logic [47:0]     da = 48'h0;
    logic            prio_use, bcast_ok, rx_discard, init_busy, sweep, age_en, age_test;
    logic [2:0]      prio, dest_mask;
    int              n_mismatch = 0;
    int              checks = 0;
    int              gap;

    satsc_top #(.INIT_CYCLES(INIT_N), .MS_CYCLES(MS_N)) satsc_top_inst (
        .i_mclk(i_mclk), .i_sys_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_sel(sel), .i_wb_adr(adr), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_cmd_start(cmd_start), .i_cmd_done(cmd_done), .i_entry_load(entry_load), .i_entry(entry),
        .i_global_da_prio(gprio), .i_lookup_da(da), .o_prio_use(prio_use), .o_prio(prio),
        .o_dest_mask(dest_mask), .o_bcast_ok(bcast_ok), .o_rx_discard(rx_discard),
        .o_init_busy(init_busy), .o_age_sweep(sweep), .o_age_en(age_en), .o_age_test(age_test));

    initial begin
        forever #20 i_mclk = ~i_mclk;
    end

    task automatic finish_test;
        if (n_mismatch == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    // Request held until ack is sampled high at a rising edge
    task automatic wb_xfer(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge i_mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do begin
            @(posedge i_mclk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        // A missing ack ends the run through the common verdict
        if (n >= 50) begin
            n_mismatch++;
            $display("[ERR] ack expected 1 seen %b", ack);
            finish_test();
        end
    endtask : wb_xfer

    task automatic do_reset(input int n);
        @(posedge i_mclk);
        rst <= 1'b1;
        repeat (n) @(posedge i_mclk);
        rst <= 1'b0;
    endtask : do_reset

    // Status and config right after any reset, then init completion
    task automatic reset_and_init;
        wb_xfer(1'b0, A_STS, 32'h0, rd);
        `CHK("sts_rst", 32'h0000_0000, rd)
        `CHK("discard", 1'b1, rx_discard)
        `CHK("init_busy", 1'b1, init_busy)
        wb_xfer(1'b0, A_CFG, 32'h0, rd);
        `CHK("cfg_rst", 32'h0129_0002, rd & 32'h0fff_0007)
        `CHK("age_en_rst", 1'b1, age_en)
        `CHK("age_test_rst", 1'b0, age_test)
        repeat (INIT_N + 4) @(posedge i_mclk);
        wb_xfer(1'b0, A_STS, 32'h0, rd);
        `CHK("sts_init", 32'h0000_0002, rd)
        `CHK("discard_end", 1'b0, rx_discard)
    endtask : reset_and_init

    task automatic cmd_pending;
        @(posedge i_mclk);
        cmd_start <= 1'b1;
        @(posedge i_mclk);
        cmd_start <= 1'b0;
        wb_xfer(1'b0, A_STS, 32'h0, rd);
        `CHK("pending", 32'h0000_0003, rd)
        @(posedge i_mclk);
        cmd_done <= 1'b1;
        @(posedge i_mclk);
        cmd_done <= 1'b0;
        wb_xfer(1'b0, A_STS, 32'hffff_ffff, rd);
        `CHK("pending_clr", 32'h0000_0002, rd)
        wb_xfer(1'b1, A_STS, 32'hffff_ffff, rd);
        wb_xfer(1'b0, A_STS, 32'h0, rd);
        `CHK("sts_ro", 32'h0000_0002, rd)
        wb_xfer(1'b0, 16'h6030, 32'h0, rd);
        `CHK("unmapped", 32'h0000_0000, rd)
    endtask : cmd_pending

    // Every port code, every combination of entry and global priority enables
    task automatic entry_codes;
        logic [2:0]      mask_tab [8];
        satsc_entry_type e;
        mask_tab = '{3'b001, 3'b010, 3'b100, 3'b000, 3'b011, 3'b101, 3'b110, 3'b111};
        for (int i = 0; i < 8; i++) begin
            e = '{prio: 3'h5, prio_en: i[0], ports: i[2:0], mac_tail: 16'h8e01 + 16'(i),
                  valid: 1'b1, end_tbl: i[2], age1: i[1], stat: 1'b0, age0: 1'b1};
            @(posedge i_mclk);
            entry <= e;
            entry_load <= 1'b1;
            gprio <= i[1];
            @(posedge i_mclk);
            entry_load <= 1'b0;
            repeat (3) @(posedge i_mclk);
            `CHK("prio_use", i[0] & i[1], prio_use)
            `CHK("prio", 3'h5, prio)
            if (i != 3) `CHK("dest_mask", mask_tab[i], dest_mask)
            `CHK("multi_port", i[2], $countones(dest_mask) > 1)
            wb_xfer(1'b0, A_RDBK, 32'h0, rd);
            `CHK("rdbk", {4'h0, e.end_tbl, e.valid, e.age1, e.stat, e.age0, e.prio_en, e.prio,
                  e.ports, e.mac_tail}, rd)
            `CHK("mac_msb", 1'b1, rd[15])
        end
    endtask : entry_codes

    task automatic sweep_gap(output int g);
        int n;
        n = 0;
        g = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (sweep !== 1'b1 && n < 9000);
        do begin
            @(posedge i_mclk);
            g++;
        end while (sweep !== 1'b1 && g < 9000);
    endtask : sweep_gap

    task automatic aging_cfg;
        wb_xfer(1'b1, A_CFG, 32'h0001_0003, rd);
        wb_xfer(1'b0, A_CFG, 32'h0, rd);
        `CHK("cfg_rw", 32'h0001_0003, rd & 32'h0fff_0007)
        `CHK("age_test", 1'b1, age_test)
        sweep_gap(gap);
        `CHK("gap_ms", 2 * MS_N, gap)
        @(posedge i_mclk);
        da <= 48'hffff_ffff_ffff;
        repeat (3) @(posedge i_mclk);
        `CHK("bcast_block", 1'b0, bcast_ok)
        wb_xfer(1'b1, A_CFG, 32'h0000_0006, rd);
        repeat (3) @(posedge i_mclk);
        `CHK("bcast_allow", 1'b1, bcast_ok)
        sweep_gap(gap);
        `CHK("gap_s", MS_N * 1000, gap)
        wb_xfer(1'b1, A_CFG, 32'h0000_0001, rd);
        `CHK("age_off", 1'b0, age_en)
        da <= 48'h0012_3456_789a;
        for (int k = 0; k < 100; k++) begin
            @(posedge i_mclk);
            `CHK("no_sweep", 1'b0, sweep)
        end
        `CHK("bcast_unicast", 1'b1, bcast_ok)
    endtask : aging_cfg

    initial begin
        repeat (20) @(posedge i_mclk);
        rst <= 1'b0;
        reset_and_init();
        cmd_pending();
        entry_codes();
        aging_cfg();
        do_reset(3);
        reset_and_init();
        finish_test();
    end

    // Whole run needs about 8300 cycles
    initial begin
        repeat (40000) @(posedge i_mclk);
        n_mismatch++;
        finish_test();
    end
endmodule : satsc_top_bench
